// ### rtl/tcr_timer16.sv
// Purpose: 16-bit timer/counter register block with capture, two compares and flags.
// Assumes: APB slave, zero-wait setup then one extra access cycle; pins synchronous to clk.
// Notes: Counting is always upward to the mode's top; dual-slope sequences are not modelled.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - With filter on, filtered input changes only after four equal samples.
// - Filter adds five sample cycles of delay before capture is seen.
// - Edge select bit: zero means falling edge, one means rising edge.
// - Capture trigger copies the 16-bit count and sets the capture flag.
// - In capture-as-top modes pin captures are disabled.
// - Clock select: stop, /1, /8, /64, /256, /1024, external fall, external rise.
// - External clock pin counts regardless of its pin direction.
// - Force bit in non-PWM mode applies compare action to output.
// - Force raises no interrupt, never clears counter; force bits read zero.
// - 16-bit writes, and count and capture reads, go through one shared 8-bit high-byte latch.
// - Writing the count blocks compare matches on the next timer tick.
// - Compare values are compared continuously against the count.
// - Capture source is the capture pin or the comparator output.
// - Interrupt request needs enable bit, global enable and flag.
// - In capture-as-top modes capture flag sets when count reaches top.
// - Flags clear on vector acknowledge or on a written one.
// - Compare flags set in the timer cycle after count equals compare.
// - Force strobe leaves compare flags unchanged.
// - Overflow flag sets at overflow in normal and clear-on-match modes.
// - Mode field splits: low bits in control A, high bits in control B.
module tcr_timer16 (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tcr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer pins and sources
  input wire logic ext_count_pin,
  input wire logic capture_pin,
  input wire logic comparatorOut,
  // Interrupt side
  input wire logic [3:0] vectorAck,
  output logic [3:0] irqReq,
  // Compare outputs
  output logic cmp_out_a,
  output logic cmp_out_b
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  localparam int FLT_W = tcr_pkg::FILTER_SAMPLES;
  logic [7:0] ctrlA_q, ctrlB_q, mask_q, flags_q, misc_q, temp_q;
  logic [15:0] count_q, capt_q;
  logic [15:0] cmpVal_q [2];
  logic [9:0] pre_q;
  logic extSample_q, extPrev_q;
  logic captSample_q, filt_q, lvlPrev_q;
  logic [FLT_W-1:0] hist_q;
  logic blockMatch_q;
  logic cmpOut_q [2];
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic [3:0] irqReq_q;

  // ----------------------------------------------------------------
  // Mode decoding helpers
  // ----------------------------------------------------------------
  // Modes where the capture register is the top value.
  function automatic logic captIsTop(input logic [3:0] m);
    captIsTop = (m == 4'h8) || (m == 4'hA) || (m == 4'hC) || (m == 4'hE);
  endfunction

  // Normal and both clear-on-match modes are the only non-PWM modes.
  function automatic logic nonPwm(input logic [3:0] m);
    nonPwm = (m == tcr_pkg::MODE_NORMAL) || (m == tcr_pkg::MODE_CTC_A) ||
             (m == tcr_pkg::MODE_CTC_CAPT);
  endfunction

  // Compare action per output mode: toggle, clear or set; 00 keeps the level.
  function automatic logic cmpAction(input logic [1:0] om, input logic cur);
    unique case (om)
      2'b01: cmpAction = ~cur;
      2'b10: cmpAction = 1'b0;
      2'b11: cmpAction = 1'b1;
      default: cmpAction = cur;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic [9:0] idx = paddr[tcr_pkg::ADDR_W-1:2];
  wire logic [3:0] waveMode = {ctrlB_q[4:3], ctrlA_q[1:0]};
  wire logic [2:0] clkSelect = ctrlB_q[2:0];
  wire logic [1:0] cmpOutModeA = ctrlA_q[7:6];
  wire logic [1:0] cmpOutModeB = ctrlA_q[5:4];
  wire logic hitReg = (idx == tcr_pkg::IDX_FLAGS) || (idx == tcr_pkg::IDX_MASK) ||
                      (idx >= tcr_pkg::IDX_CTRL_A && idx <= tcr_pkg::IDX_CMPB_H);
  wire logic mapped = hitReg && (paddr[1:0] == 2'b00);
  // The data phase is taken one cycle after penable rises; writes land at the pready edge.
  wire logic accessCap = psel && penable && !pready_q;
  wire logic accept = psel && penable && pready_q;
  wire logic wrEn = accept && pwrite && pstrb[0] && mapped;
  wire logic rdEn = accessCap && !pwrite && mapped;
  wire logic [7:0] wb = pwdata[7:0];
  wire logic wrHigh = wrEn && ((idx == tcr_pkg::IDX_COUNT_H) || (idx == tcr_pkg::IDX_CAPT_H) ||
                      (idx == tcr_pkg::IDX_CMPA_H) || (idx == tcr_pkg::IDX_CMPB_H));
  wire logic wrCount = wrEn && (idx == tcr_pkg::IDX_COUNT_L);
  wire logic wrCapt = wrEn && (idx == tcr_pkg::IDX_CAPT_L);
  wire logic wrForce = wrEn && (idx == tcr_pkg::IDX_CTRL_C);
  wire logic [1:0] wrCmp = {wrEn && (idx == tcr_pkg::IDX_CMPB_L),
                            wrEn && (idx == tcr_pkg::IDX_CMPA_L)};
  wire logic rdCountL = rdEn && (idx == tcr_pkg::IDX_COUNT_L);
  wire logic rdCaptL = rdEn && (idx == tcr_pkg::IDX_CAPT_L);

  // Read mux; force bits and reserved bit always read zero.
  logic [7:0] rdByte;
  always_comb begin
    rdByte = 8'h00;
    unique case (idx)
      tcr_pkg::IDX_FLAGS: rdByte = flags_q;
      tcr_pkg::IDX_MASK: rdByte = mask_q;
      tcr_pkg::IDX_CTRL_A: rdByte = ctrlA_q;
      tcr_pkg::IDX_CTRL_B: rdByte = ctrlB_q & tcr_pkg::CTRL_B_MASK;
      tcr_pkg::IDX_MISC: rdByte = misc_q;
      tcr_pkg::IDX_COUNT_L: rdByte = count_q[7:0];
      tcr_pkg::IDX_CAPT_L: rdByte = capt_q[7:0];
      tcr_pkg::IDX_COUNT_H: rdByte = temp_q;
      tcr_pkg::IDX_CAPT_H: rdByte = temp_q;
      tcr_pkg::IDX_CMPA_L: rdByte = cmpVal_q[0][7:0];
      tcr_pkg::IDX_CMPA_H: rdByte = cmpVal_q[0][15:8];
      tcr_pkg::IDX_CMPB_L: rdByte = cmpVal_q[1][7:0];
      tcr_pkg::IDX_CMPB_H: rdByte = cmpVal_q[1][15:8];
      default: rdByte = 8'h00;
    endcase
  end

  // Bus answer: pready rises one cycle into the access phase, data is ready with it.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= accessCap;
      pslverr_q <= accessCap && !mapped;
      if (accessCap) begin
        prdata_q <= (mapped && !pwrite) ? {24'h00_0000, rdByte} : 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Timer clock source
  // ----------------------------------------------------------------
  // The prescaler runs free, so the first prescaled tick may come early after enabling.
  wire logic extRise = extSample_q && !extPrev_q;
  wire logic extFall = !extSample_q && extPrev_q;
  logic tick;
  always_comb begin
    unique case (clkSelect)
      tcr_pkg::CS_STOP: tick = 1'b0;
      tcr_pkg::CS_DIV1: tick = 1'b1;
      tcr_pkg::CS_DIV8: tick = (pre_q & tcr_pkg::PRE_MASK8) == tcr_pkg::PRE_MASK8;
      tcr_pkg::CS_DIV64: tick = (pre_q & tcr_pkg::PRE_MASK64) == tcr_pkg::PRE_MASK64;
      tcr_pkg::CS_DIV256: tick = (pre_q & tcr_pkg::PRE_MASK256) == tcr_pkg::PRE_MASK256;
      tcr_pkg::CS_DIV1024: tick = pre_q == tcr_pkg::PRE_MASK1024;
      tcr_pkg::CS_EXT_FALL: tick = extFall;
      default: tick = extRise;
    endcase
  end

  // Pin sampling ignores direction; the pin level alone drives the edge detector.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pre_q <= 10'h000;
      extSample_q <= 1'b0;
      extPrev_q <= 1'b0;
    end else begin
      pre_q <= pre_q + 10'h001;
      extSample_q <= ext_count_pin;
      extPrev_q <= extSample_q;
    end
  end

  // ----------------------------------------------------------------
  // Counter, top and overflow
  // ----------------------------------------------------------------
  logic [15:0] topVal;
  always_comb begin
    unique case (waveMode)
      4'h1, 4'h5: topVal = 16'h00FF;
      4'h2, 4'h6: topVal = 16'h01FF;
      4'h3, 4'h7: topVal = 16'h03FF;
      4'h4, 4'h9, 4'hB, 4'hF: topVal = cmpVal_q[0];
      4'h8, 4'hA, 4'hC, 4'hE: topVal = capt_q;
      default: topVal = tcr_pkg::COUNT_MAX;
    endcase
  end
  wire logic atTop = count_q == topVal;
  wire logic ovfEvent = tick && (nonPwm(waveMode) ? (count_q == tcr_pkg::COUNT_MAX) : atTop);

  // A software write wins over a tick in the same cycle and arms the match block.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      count_q <= tcr_pkg::RESET_WORD;
      blockMatch_q <= 1'b0;
    end else begin
      if (wrCount) begin
        count_q <= {temp_q, wb};
      end else if (tick) begin
        count_q <= atTop ? tcr_pkg::RESET_WORD : count_q + 16'h0001;
      end
      if (wrCount) begin
        blockMatch_q <= 1'b1;
      end else if (tick) begin
        blockMatch_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Capture path
  // ----------------------------------------------------------------
  wire logic captSrc = misc_q[tcr_pkg::B_CAPT_SRC] ? comparatorOut : capture_pin;
  wire logic filtEn = ctrlB_q[tcr_pkg::B_FILT_EN];
  wire logic allHigh = &hist_q;
  wire logic allLow = ~|hist_q;
  wire logic captLvl = filtEn ? filt_q : captSample_q;
  wire logic edgeSeen = ctrlB_q[tcr_pkg::B_EDGE_SEL] ? (captLvl && !lvlPrev_q) :
                        (!captLvl && lvlPrev_q);
  wire logic pinCapt = edgeSeen && !captIsTop(waveMode);
  wire logic topCapt = tick && atTop && captIsTop(waveMode);

  // The filter follows only when the whole history agrees, which costs four samples.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      captSample_q <= 1'b0;
      hist_q <= '0;
      filt_q <= 1'b0;
      lvlPrev_q <= 1'b0;
    end else begin
      captSample_q <= captSrc;
      hist_q <= {hist_q[FLT_W-2:0], captSample_q};
      if (allHigh) begin
        filt_q <= 1'b1;
      end else if (allLow) begin
        filt_q <= 1'b0;
      end
      lvlPrev_q <= captLvl;
    end
  end

  // Capture register takes the count on a pin event; software may also load it.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      capt_q <= tcr_pkg::RESET_WORD;
    end else if (pinCapt) begin
      capt_q <= count_q;
    end else if (wrCapt) begin
      capt_q <= {temp_q, wb};
    end
  end

  // ----------------------------------------------------------------
  // Compare channels
  // ----------------------------------------------------------------
  logic [1:0] matchSet;
  wire logic [1:0] forceHit = {wrForce && wb[tcr_pkg::B_FORCE_B],
                               wrForce && wb[tcr_pkg::B_FORCE_A]} &
                              {2{nonPwm(waveMode)}};
  wire logic [1:0] outMode [2];
  assign outMode[0] = cmpOutModeA;
  assign outMode[1] = cmpOutModeB;

  // One slice per channel; the match is seen at the tick that ends the equal cycle.
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : gCmp
      assign matchSet[ch] = tick && !blockMatch_q && (count_q == cmpVal_q[ch]);

      always_ff @(posedge clk) begin
        if (!rstn) begin
          cmpVal_q[ch] <= tcr_pkg::RESET_WORD;
          cmpOut_q[ch] <= 1'b0;
        end else begin
          if (wrCmp[ch]) begin
            cmpVal_q[ch] <= {temp_q, wb};
          end
          if (forceHit[ch] || (matchSet[ch] && nonPwm(waveMode))) begin
            cmpOut_q[ch] <= cmpAction(outMode[ch], cmpOut_q[ch]);
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Control, temp latch, flags and requests
  // ----------------------------------------------------------------
  wire logic [7:0] flagSet = {2'b00, (pinCapt || topCapt), 2'b00, matchSet[1], matchSet[0],
                              ovfEvent};
  wire logic [7:0] w1c = (wrEn && idx == tcr_pkg::IDX_FLAGS) ? wb : 8'h00;
  wire logic [7:0] ackClr = {2'b00, vectorAck[3], 2'b00, vectorAck[2:0]};
  wire logic [7:0] flagsNext = ((flags_q & ~(w1c | ackClr)) | flagSet) &
                               tcr_pkg::IRQ_BITS_MASK;
  wire logic [7:0] pend = flags_q & mask_q & {8{misc_q[tcr_pkg::B_GLOBAL_IE]}};

  // A new event in the clearing cycle survives: set beats clear.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrlA_q <= tcr_pkg::RESET_BYTE;
      ctrlB_q <= tcr_pkg::RESET_BYTE;
      mask_q <= tcr_pkg::RESET_BYTE;
      misc_q <= tcr_pkg::RESET_BYTE;
      flags_q <= tcr_pkg::RESET_BYTE;
      temp_q <= tcr_pkg::RESET_BYTE;
      irqReq_q <= 4'h0;
    end else begin
      if (wrEn && idx == tcr_pkg::IDX_CTRL_A) ctrlA_q <= wb;
      if (wrEn && idx == tcr_pkg::IDX_CTRL_B) ctrlB_q <= wb & tcr_pkg::CTRL_B_MASK;
      if (wrEn && idx == tcr_pkg::IDX_MASK) mask_q <= wb & tcr_pkg::IRQ_BITS_MASK;
      if (wrEn && idx == tcr_pkg::IDX_MISC) misc_q <= wb & 8'h03;
      flags_q <= flagsNext;
      if (wrHigh) begin
        temp_q <= wb;
      end else if (rdCountL) begin
        temp_q <= count_q[15:8];
      end else if (rdCaptL) begin
        temp_q <= capt_q[15:8];
      end
      irqReq_q <= {pend[tcr_pkg::F_CAPT], pend[tcr_pkg::F_CMPB], pend[tcr_pkg::F_CMPA],
                   pend[tcr_pkg::F_OVF]};
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irqReq = irqReq_q;
  assign cmp_out_a = cmpOut_q[0];
  assign cmp_out_b = cmpOut_q[1];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_FILTER_STABLE: assert property (@(posedge clk) disable iff (!rstn)
    filtEn && $changed(filt_q) |-> $past(allHigh) || $past(allLow))
    else $error("Filtered capture level changed without four equal samples.");

  AST_EDGE_RISE: assert property (@(posedge clk) disable iff (!rstn)
    pinCapt && ctrlB_q[tcr_pkg::B_EDGE_SEL] |-> captLvl && !lvlPrev_q)
    else $error("Rising-edge capture fired on a non-rising edge.");

  AST_CAPT_COPY: assert property (@(posedge clk) disable iff (!rstn)
    pinCapt |=> capt_q == $past(count_q) && flags_q[tcr_pkg::F_CAPT])
    else $error("Capture did not copy the count or set the flag.");

  AST_NO_PIN_CAPT: assert property (@(posedge clk) disable iff (!rstn)
    captIsTop(waveMode) |-> !pinCapt)
    else $error("Pin capture taken while capture is the top value.");

  AST_BLOCK_MATCH: assert property (@(posedge clk) disable iff (!rstn)
    wrCount ##1 (!wrCount && tick) |=> !flags_q[tcr_pkg::F_CMPA] || $past(flags_q[tcr_pkg::F_CMPA]))
    else $error("Compare A flag set on the tick right after a count write.");

  AST_FORCE_NO_FLAG: assert property (@(posedge clk) disable iff (!rstn)
    forceHit[0] && !matchSet[0] && !flags_q[tcr_pkg::F_CMPA] |=> !flags_q[tcr_pkg::F_CMPA])
    else $error("Force strobe set the compare A flag.");

  AST_MATCH_NEXT: assert property (@(posedge clk) disable iff (!rstn)
    matchSet[1] |=> flags_q[tcr_pkg::F_CMPB])
    else $error("Compare B flag not set after a match tick.");

  AST_IRQ_GATE: assert property (@(posedge clk) disable iff (!rstn)
    irqReq_q[0] |-> $past(flags_q[tcr_pkg::F_OVF] && mask_q[tcr_pkg::F_OVF] &&
                          misc_q[tcr_pkg::B_GLOBAL_IE]))
    else $error("Overflow request without flag, enable and global enable.");

  AST_STOPPED: assert property (@(posedge clk) disable iff (!rstn)
    clkSelect == tcr_pkg::CS_STOP && !wrCount |=> count_q == $past(count_q))
    else $error("Counter moved with no clock source selected.");

  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!rstn)
    pready_q && idx == tcr_pkg::IDX_CTRL_B |-> prdata_q[5] == 1'b0)
    else $error("Reserved control bit read back as one.");

endmodule

`default_nettype wire

// ### rtl/tcr_pkg.sv
// Purpose: Shared constants for the 16-bit timer with capture and compare units.
// Assumes: APB with 32-bit data; each register index sits at byte address index*4.
// Notes: Register indices are 8-bit locations; only the low byte of each word is used.
`default_nettype none

package tcr_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_FLAGS = 10'h036;
  localparam logic [9:0] IDX_MASK = 10'h06F;
  localparam logic [9:0] IDX_CTRL_A = 10'h080;
  localparam logic [9:0] IDX_CTRL_B = 10'h081;
  localparam logic [9:0] IDX_CTRL_C = 10'h082;
  localparam logic [9:0] IDX_MISC = 10'h083;
  localparam logic [9:0] IDX_COUNT_L = 10'h084;
  localparam logic [9:0] IDX_COUNT_H = 10'h085;
  localparam logic [9:0] IDX_CAPT_L = 10'h086;
  localparam logic [9:0] IDX_CAPT_H = 10'h087;
  localparam logic [9:0] IDX_CMPA_L = 10'h088;
  localparam logic [9:0] IDX_CMPA_H = 10'h089;
  localparam logic [9:0] IDX_CMPB_L = 10'h08A;
  localparam logic [9:0] IDX_CMPB_H = 10'h08B;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int B_FILT_EN = 7;
  localparam int B_EDGE_SEL = 6;
  localparam int B_FORCE_A = 7;
  localparam int B_FORCE_B = 6;
  localparam int B_CAPT_SRC = 0;
  localparam int B_GLOBAL_IE = 1;
  localparam int F_CAPT = 5;
  localparam int F_CMPB = 2;
  localparam int F_CMPA = 1;
  localparam int F_OVF = 0;
  localparam logic [7:0] CTRL_B_MASK = 8'hDF;
  localparam logic [7:0] IRQ_BITS_MASK = 8'h27;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // ----------------------------------------------------------------
  // Clock select codes, waveform modes, filter length
  // ----------------------------------------------------------------
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_CTC_A = 4'h4;
  localparam logic [3:0] MODE_CTC_CAPT = 4'hC;
  localparam int FILTER_SAMPLES = 4;
  localparam logic [9:0] PRE_MASK8 = 10'h007;
  localparam logic [9:0] PRE_MASK64 = 10'h03F;
  localparam logic [9:0] PRE_MASK256 = 10'h0FF;
  localparam logic [9:0] PRE_MASK1024 = 10'h3FF;
endpackage

`default_nettype wire

// ### bench/tcr_pin_model.sv
// Purpose: Far-side model of the timer pins: capture input, count input, vector acknowledges.
// Assumes: Pins change only just after a rising clock edge.
// Notes: The comparator source idles low and pulses only when a test asks for it.
`timescale 1ns/100ps
`default_nettype none

module tcr_pin_model (
  // Clock
  input wire logic clk,
  // Pins towards the timer
  output logic capturePin,
  output logic extPin,
  output logic compOut,
  output logic [3:0] ackPulse
);
  // Idle levels at time zero.
  initial begin
    capturePin = 1'b0;
    extPin = 1'b0;
    compOut = 1'b0;
    ackPulse = 4'h0;
  end

  // One high pulse; a short one lets the filter prove that it rejects glitches.
  task automatic pulse_capture(input int len);
    @(posedge clk) capturePin <= 1'b1;
    repeat (len) @(posedge clk);
    capturePin <= 1'b0;
  endtask

  // Same pulse on the comparator output, the alternative capture source.
  task automatic pulse_comp(input int len);
    @(posedge clk) compOut <= 1'b1;
    repeat (len) @(posedge clk);
    compOut <= 1'b0;
  endtask

  // High half is two clocks and low half three, slow enough for the pin sampler.
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge clk) extPin <= 1'b1;
      repeat (2) @(posedge clk);
      extPin <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  // A vector acknowledge lasts exactly one clock.
  task automatic ack(input logic [3:0] v);
    @(posedge clk) ackPulse <= v;
    @(posedge clk) ackPulse <= 4'h0;
  endtask
endmodule

`default_nettype wire

// ### bench/tb_top.sv
// Purpose: Self-checking bench for the 16-bit timer register block.
// Assumes: Counter is stopped whenever a value is read, so expectations are exact.
// Notes: Inputs change only by non-blocking assignment after a rising edge.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic clk = 1'b0;
  logic rstn, psel, penable, pwrite, pready, pslverr, extPin, capturePin, compOut;
  logic cmpOutA, cmpOutB, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb, vectorAck, irqReq;
  int num_errors = 0;
  int cmp_count = 0;
  logic [7:0] capCtl[5] = '{8'h40, 8'h00, 8'hC0, 8'hC0, 8'h58};
  int capLen[5] = '{8, 8, 3, 8, 8};
  logic [7:0] capFlag[5] = '{8'h20, 8'h20, 8'h00, 8'h20, 8'h00};
  logic [15:0] cntInit[3] = '{16'h0010, 16'h000E, 16'hFFFE};
  logic [7:0] cntFlag[3] = '{8'h00, 8'h02, 8'h03};

  // ----------------------------------------------------------------
  // Clock, design and pin model
  // ----------------------------------------------------------------
  always #5 clk = ~clk;
  tcr_timer16 dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_count_pin(extPin), .capture_pin(capturePin),
    .comparatorOut(compOut), .vectorAck(vectorAck), .irqReq(irqReq),
    .cmp_out_a(cmpOutA), .cmp_out_b(cmpOutB));
  tcr_pin_model pins (.clk(clk), .capturePin(capturePin), .extPin(extPin),
    .compOut(compOut), .ackPulse(vectorAck));

  // ----------------------------------------------------------------
  // Access and check tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // The request is held until pready is seen high; only the watchdog ends a hung wait.
  task automatic apb(input logic [9:0] idx, input logic wr, input logic [7:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    pstrb <= 4'hF;
    @(posedge clk) penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, d);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
    apb(idx, 1'b0, 8'h00);
    chk(rdat, {24'h000000, exp});
  endtask

  // High byte first so the shared latch holds it when the low byte lands.
  task automatic wr16(input logic [9:0] hi, input logic [9:0] lo, input logic [15:0] v);
    wr(hi, v[15:8]);
    wr(lo, v[7:0]);
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(tcr_pkg::IDX_CTRL_B, 8'h00);
    rd(tcr_pkg::IDX_COUNT_L, 8'h00);
    rd(tcr_pkg::IDX_FLAGS, 8'h00);
    apb(10'h000, 1'b0, 8'h00);
    chk({31'h0, err}, 32'h1);
    wr(tcr_pkg::IDX_CTRL_B, 8'hDF);
    rd(tcr_pkg::IDX_CTRL_B, 8'hDF);
    wr(tcr_pkg::IDX_CTRL_B, 8'h00);
    // External count on both edge settings, five pulses each.
    for (int cs = 6; cs < 8; cs++) begin
      wr16(tcr_pkg::IDX_COUNT_H, tcr_pkg::IDX_COUNT_L, 16'h0000);
      wr(tcr_pkg::IDX_CTRL_B, 8'(cs));
      pins.ext_pulses(5);
      repeat (6) @(posedge clk);
      wr(tcr_pkg::IDX_CTRL_B, 8'h00);
      rd(tcr_pkg::IDX_COUNT_L, 8'h05);
      rd(tcr_pkg::IDX_COUNT_H, 8'h00);
    end
    // A count equal to compare A must not match on the first tick; the last run wraps.
    wr16(tcr_pkg::IDX_CMPA_H, tcr_pkg::IDX_CMPA_L, 16'h0010);
    wr16(tcr_pkg::IDX_CMPB_H, tcr_pkg::IDX_CMPB_L, 16'h0100);
    rd(tcr_pkg::IDX_CMPA_L, 8'h10);
    for (int i = 0; i < 3; i++) begin
      wr(tcr_pkg::IDX_FLAGS, 8'h27);
      wr16(tcr_pkg::IDX_COUNT_H, tcr_pkg::IDX_COUNT_L, cntInit[i]);
      wr(tcr_pkg::IDX_CTRL_B, {5'h00, tcr_pkg::CS_DIV1});
      repeat (30) @(posedge clk);
      wr(tcr_pkg::IDX_CTRL_B, 8'h00);
      rd(tcr_pkg::IDX_FLAGS, cntFlag[i]);
    end
    wr(tcr_pkg::IDX_MASK, 8'h02);
    wr(tcr_pkg::IDX_MISC, 8'h02);
    repeat (3) @(posedge clk);
    chk(irqReq, 4'h2);
    pins.ack(4'h2);
    repeat (3) @(posedge clk);
    chk(irqReq, 4'h0);
    rd(tcr_pkg::IDX_FLAGS, 8'h01);
    wr(tcr_pkg::IDX_MASK, 8'h00);
    // Capture: rising, falling, filtered glitch, filtered pulse, capture-as-top mode.
    for (int i = 0; i < 5; i++) begin
      wr(tcr_pkg::IDX_FLAGS, 8'h27);
      wr16(tcr_pkg::IDX_COUNT_H, tcr_pkg::IDX_COUNT_L, 16'h0150 + 16'(i));
      wr(tcr_pkg::IDX_CTRL_B, capCtl[i]);
      pins.pulse_capture(capLen[i]);
      repeat (12) @(posedge clk);
      rd(tcr_pkg::IDX_FLAGS, capFlag[i]);
      if (capFlag[i] != 8'h00) begin
        rd(tcr_pkg::IDX_CAPT_L, 8'h50 + 8'(i));
        rd(tcr_pkg::IDX_CAPT_H, 8'h01);
      end
    end
    // Comparator as capture source: a pin pulse is then ignored.
    wr(tcr_pkg::IDX_MISC, 8'h01);
    wr(tcr_pkg::IDX_FLAGS, 8'h27);
    wr(tcr_pkg::IDX_CTRL_B, 8'h40);
    pins.pulse_capture(8);
    repeat (12) @(posedge clk);
    rd(tcr_pkg::IDX_FLAGS, 8'h00);
    pins.pulse_comp(8);
    repeat (12) @(posedge clk);
    rd(tcr_pkg::IDX_FLAGS, 8'h20);
    rd(tcr_pkg::IDX_CAPT_L, 8'h54);
    // Capture register as top: the flag comes from reaching top.
    wr16(tcr_pkg::IDX_CAPT_H, tcr_pkg::IDX_CAPT_L, 16'h0005);
    wr16(tcr_pkg::IDX_COUNT_H, tcr_pkg::IDX_COUNT_L, 16'h0000);
    wr(tcr_pkg::IDX_FLAGS, 8'h27);
    wr(tcr_pkg::IDX_CTRL_B, 8'h19);
    repeat (20) @(posedge clk);
    wr(tcr_pkg::IDX_CTRL_B, 8'h00);
    rd(tcr_pkg::IDX_FLAGS, 8'h20);
    // Forced compare: toggle on A, disconnected B, no flag.
    wr(tcr_pkg::IDX_CTRL_B, 8'h00);
    wr(tcr_pkg::IDX_CTRL_A, 8'h41);
    wr(tcr_pkg::IDX_CTRL_C, 8'h00);
    wr(tcr_pkg::IDX_CTRL_A, 8'h40);
    wr(tcr_pkg::IDX_FLAGS, 8'h27);
    wr(tcr_pkg::IDX_CTRL_C, 8'hC0);
    repeat (2) @(posedge clk);
    chk(cmpOutA, 32'h1);
    chk(cmpOutB, 32'h0);
    rd(tcr_pkg::IDX_CTRL_C, 8'h00);
    rd(tcr_pkg::IDX_FLAGS, 8'h00);
    end_sim();
  end

  // Watchdog well beyond the several hundred cycles the sequence needs.
  initial begin
    #300us;
    num_errors++;
    end_sim();
  end
endmodule

`default_nettype wire
